// ==== hdl/acpi_memory_power_sequencer.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "power_seq_consts.svh"
// Functional notes
// R01: Start in S5 with regulators off
// R02: Enter S0 when supplies good, sleeps high
// R03: Sleep-to-RAM falling in S0 enters S3
// R04: Sleep-to-RAM rising in S3 returns S0
// R05: Soft-off low forces S5, all off
// R06: Mode logic waits for reference good
// R07: Standby, then boot monitor, then ramp
// R08: Memory in-regulation enables termination and hub
// R09: Memory PWM at 250 kHz fixed in S0
// R10: S3 doubles memory switching frequency
// R11: Gate outputs per mode table
// R12: Gate pairs never on together
// R13: Switch node low latches all off
// R14: Latch clears on supply or soft-off cycle
// R15: Overcurrent disabled in S3
// R16: Termination only in S0 with regulation
// R17: Hub like memory, faster ramp, no fault
// R18: Ignore overcurrent 400 ns after turn-on
// R19: Memory and hub 180 degrees apart
// R20: Over-temperature shutdown with hysteresis
// R21: Synchronise sleeps and good flags
module acpi_memory_power_sequencer
  import power_seq_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        clockEnable,
  // Chipset and monitors
  input  wire logic        sleepToRamN,
  input  wire logic        softOffN,
  input  wire logic        referenceGood,
  input  wire logic        standbySupplyGood,
  input  wire logic        bootSupplyGood,
  input  wire logic        switchNodeBelowThreshold,
  input  wire logic        termCurrentLimit,
  input  wire logic [7:0]  dieTempC,
  // Gate drive and rail control
  output logic             memoryHighGate,
  output logic             memoryLowGate,
  output logic             hubHighGate,
  output logic             hubLowGate,
  output logic             terminationEnable,
  output logic             terminationOe,
  output logic             standbyMonitorEnable,
  output logic             bootMonitorEnable,
  output logic             memoryRailInRegulation,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  pmode_t mode_r;
  pmode_t mode_nxt;
  upseq_t up_r;
  upseq_t up_nxt;
  logic [4:0]  syncd;
  logic        slpS3;
  logic        slpS5;
  logic        refGood;
  logic        stbyGood;
  logic        bootGood;
  logic        slpS3Prev_r;
  logic        slpS5Prev_r;
  logic        stbyPrev_r;
  logic        bootPrev_r;
  logic        ocLatch_r;
  logic        hotLatch_r;
  logic [7:0]  blank_r;
  logic        memDone;
  logic        hubDone;
  logic        memRise;
  logic        hubRise;
  logic        memRun;
  logic        hubRun;
  logic        inReg_r;
  logic        swSoftOff_r;
  logic [7:0]  memDuty_r;
  logic [7:0]  hubDuty_r;
  logic        awTaken_r;
  logic        wTaken_r;
  logic [11:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;

  // Synchronised inputs; active-low pins inverted so reset reads high
  sync_level #(.W(5)) u_sync (
    .clock   (clock),
    .resetn  (resetn),
    .enable  (clockEnable),
    .rawIn   ({sleepToRamN, softOffN, referenceGood, standbySupplyGood, bootSupplyGood}),
    .initVal (5'h18),
    .syncOut (syncd)
  ); // R21
  assign slpS3    = !syncd[4];
  assign slpS5    = !syncd[3] && !swSoftOff_r;
  assign refGood  = syncd[2];
  assign stbyGood = syncd[1];
  assign bootGood = syncd[0];

  // Edge detection on synchronised levels
  wire s3Fall    = slpS3Prev_r && !slpS3;
  wire s3Rise    = !slpS3Prev_r && slpS3;
  wire s5Fall    = slpS5Prev_r && !slpS5;
  wire supplyCyc = (stbyPrev_r && !stbyGood) || (bootPrev_r && !bootGood);
  wire hot       = dieTempC >= 8'(`OVERTEMP_SET_C);
  wire cool      = dieTempC < 8'(`OVERTEMP_CLR_C);
  wire allGood   = refGood && stbyGood && bootGood;
  wire fault     = ocLatch_r || hotLatch_r;

  // Power-up monitor chain; each stage waits for the previous good
  always_comb begin
    up_nxt = up_r;
    case (up_r)
      UP_IDLE: if (refGood) up_nxt = UP_STBY; // R06
      UP_STBY: if (stbyGood) up_nxt = UP_BOOT; // R07
      UP_BOOT: if (bootGood) up_nxt = UP_RAMP; // R07
      UP_RAMP: if (!refGood || !stbyGood) up_nxt = UP_IDLE;
      default: up_nxt = UP_IDLE;
    endcase
  end

  // Mode decode; soft-off and faults take priority over sleep
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      ST_S5: if (up_r == UP_RAMP && allGood && slpS3 && slpS5 && !fault)
        mode_nxt = ST_S0; // R02
      ST_S0: begin
        if (!slpS5 || fault || !refGood) mode_nxt = ST_S5; // R05 R13 R20
        else if (s3Fall) mode_nxt = ST_S3; // R03
      end
      ST_S3: begin
        if (!slpS5 || fault || !refGood) mode_nxt = ST_S5; // R05 R13 R20
        else if (s3Rise) mode_nxt = ST_S0; // R04
      end
      default: mode_nxt = ST_S5;
    endcase
  end

  // State registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_r <= ST_S5; // R01
      up_r   <= UP_IDLE;
    end else if (clockEnable) begin
      mode_r <= mode_nxt;
      up_r   <= up_nxt;
    end
  end

  // Previous-value flops for edges
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      slpS3Prev_r <= 1'b1;
      slpS5Prev_r <= 1'b1;
      stbyPrev_r  <= 1'b0;
      bootPrev_r  <= 1'b0;
    end else if (clockEnable) begin
      slpS3Prev_r <= slpS3;
      slpS5Prev_r <= slpS5;
      stbyPrev_r  <= stbyGood;
      bootPrev_r  <= bootGood;
    end
  end

  // Blanking counter restarts on each memory high-side turn-on
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      blank_r <= '0;
    end else if (clockEnable) begin
      if (memRise) blank_r <= 8'(`BLANK_CYC); // R18
      else if (blank_r != '0) blank_r <= blank_r - 8'h01;
    end
  end

  // Overcurrent armed only in S0, after blanking, with high side on
  wire ocTrip = (mode_r == ST_S0) && memoryHighGate && (blank_r == '0) && !memRise
                && switchNodeBelowThreshold; // R13 R15 R18

  // Overcurrent latch; trip wins over a same-cycle clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ocLatch_r <= 1'b0;
    end else if (clockEnable) begin
      if (ocTrip) ocLatch_r <= 1'b1; // R13
      else if (supplyCyc || s5Fall) ocLatch_r <= 1'b0; // R14
    end
  end

  // Thermal latch with hysteresis
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hotLatch_r <= 1'b0;
    end else if (clockEnable) begin
      if (hot) hotLatch_r <= 1'b1; // R20
      else if (cool) hotLatch_r <= 1'b0; // R20
    end
  end

  // Memory rail runs in S0 and S3; hub only once regulated in S0
  assign memRun = (mode_r == ST_S0 || mode_r == ST_S3) && !fault; // R11
  assign hubRun = (mode_r == ST_S0) && inReg_r && !fault; // R08 R11 R17

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      inReg_r <= 1'b0;
    end else if (clockEnable) begin
      inReg_r <= memRun && memDone; // R08
    end
  end

  pwm_channel u_mem (
    .clock      (clock),
    .resetn     (resetn),
    .enable     (clockEnable),
    .run        (memRun),
    .fastSwitch (mode_r == ST_S3), // R10
    .phase      ('0),
    .duty       (memDuty_r),
    .ssStep     (2'h1),
    .highGate   (memoryHighGate),
    .lowGate    (memoryLowGate),
    .highRise   (memRise),
    .ssDone     (memDone)
  ); // R09

  pwm_channel u_hub (
    .clock      (clock),
    .resetn     (resetn),
    .enable     (clockEnable),
    .run        (hubRun),
    .fastSwitch (1'b0),
    .phase      (`PWM_CNT_W'(`PWM_PERIOD_CYC / 2)), // R19
    .duty       (hubDuty_r),
    .ssStep     (2'h2), // R17
    .highGate   (hubHighGate),
    .lowGate    (hubLowGate),
    .highRise   (hubRise),
    .ssDone     (hubDone)
  );

  // Termination: driven only in S0 with memory regulated, else high-Z
  assign terminationEnable      = hubRun && !termCurrentLimit; // R16
  assign terminationOe          = hubRun; // R11 R16
  assign standbyMonitorEnable   = (up_r != UP_IDLE); // R07
  assign bootMonitorEnable      = (up_r == UP_BOOT) || (up_r == UP_RAMP); // R07
  assign memoryRailInRegulation = inReg_r;

  // AXI4-Lite write: address and data in either order
  wire wrGo = awTaken_r && wTaken_r && !s_axi_bvalid;
  assign s_axi_awready = clockEnable && !awTaken_r && !s_axi_bvalid;
  assign s_axi_wready  = clockEnable && !wTaken_r && !s_axi_bvalid;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      awTaken_r    <= 1'b0;
      wTaken_r     <= 1'b0;
      awAddr_r     <= '0;
      wData_r      <= '0;
      wStrb_r      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (clockEnable) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awTaken_r <= 1'b1;
        awAddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wTaken_r <= 1'b1;
        wData_r  <= s_axi_wdata;
        wStrb_r  <= s_axi_wstrb;
      end
      if (wrGo) begin
        awTaken_r    <= 1'b0;
        wTaken_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_r[11:2] <= `REG_HUB_DUTY >> 2) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable control registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      swSoftOff_r <= 1'(`CTL_RESET_VAL >> `CTL_SOFTOFF_BIT);
      memDuty_r   <= `DUTY_RESET_VAL;
      hubDuty_r   <= `DUTY_RESET_VAL;
    end else if (clockEnable && wrGo && wStrb_r[0]) begin
      case ({awAddr_r[11:2], 2'b00})
        `REG_CONTROL:  swSoftOff_r <= wData_r[`CTL_SOFTOFF_BIT];
        `REG_MEM_DUTY: memDuty_r   <= wData_r[7:0];
        `REG_HUB_DUTY: hubDuty_r   <= wData_r[7:0];
        default:       swSoftOff_r <= swSoftOff_r;
      endcase
    end
  end

  // Read mux, registered data
  wire [11:0] rdSel = {s_axi_araddr[11:2], 2'b00};
  wire        rdOk  = rdSel <= `REG_TEMP;
  wire [31:0] statusWord = {22'h0, hubDone, fault, hotLatch_r, ocLatch_r, inReg_r,
                            up_r != UP_IDLE, bootGood, mode_r};
  wire [31:0] rdWord = (rdSel == `REG_CONTROL)  ? {31'h0, swSoftOff_r} :
                       (rdSel == `REG_STATUS)   ? statusWord :
                       (rdSel == `REG_MEM_DUTY) ? {24'h0, memDuty_r} :
                       (rdSel == `REG_HUB_DUTY) ? {24'h0, hubDuty_r} :
                       (rdSel == `REG_TEMP)     ? {24'h0, dieTempC} : 32'h0;
  assign s_axi_arready = clockEnable && !s_axi_rvalid;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= 2'b00;
    end else if (clockEnable) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdWord;
        s_axi_rresp  <= rdOk ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  a_s5_gates_low: assert property (@(posedge clock) disable iff (!resetn)
    mode_r == ST_S5 |=> !memoryHighGate && !memoryLowGate && !hubHighGate && !hubLowGate)
    else $error("gate on in S5"); // R11
  a_s3_hub_off: assert property (@(posedge clock) disable iff (!resetn)
    mode_r == ST_S3 |-> !terminationOe ##1 (!hubHighGate && !hubLowGate))
    else $error("hub or termination active in S3"); // R11
  a_softoff_s5: assert property (@(posedge clock) disable iff (!resetn)
    clockEnable && !slpS5 && mode_r != ST_S5 |=> mode_r == ST_S5)
    else $error("soft-off not obeyed"); // R05
  a_s0_to_s3: assert property (@(posedge clock) disable iff (!resetn)
    clockEnable && mode_r == ST_S0 && s3Fall && slpS5 && !fault && refGood |=> mode_r == ST_S3)
    else $error("missed S3 entry"); // R03
  a_s3_to_s0: assert property (@(posedge clock) disable iff (!resetn)
    clockEnable && mode_r == ST_S3 && s3Rise && slpS5 && !fault && refGood
    |=> mode_r == ST_S0) else $error("missed S0 return"); // R04
  a_s0_entry: assert property (@(posedge clock) disable iff (!resetn)
    $changed(mode_r) && mode_r == ST_S0 && $past(mode_r) == ST_S5 |-> $past(allGood))
    else $error("S0 without supplies"); // R02
  a_oc_latch: assert property (@(posedge clock) disable iff (!resetn)
    clockEnable && ocTrip |=> ocLatch_r ##1 mode_r == ST_S5)
    else $error("overcurrent not latched"); // R13
  a_oc_s3_off: assert property (@(posedge clock) disable iff (!resetn)
    mode_r == ST_S3 && !ocLatch_r |=> !ocLatch_r) else $error("overcurrent armed in S3"); // R15
  a_term_inreg: assert property (@(posedge clock) disable iff (!resetn)
    terminationOe |-> inReg_r && mode_r == ST_S0) else $error("termination early"); // R16
  c_enter_s0: cover property (@(posedge clock) disable iff (!resetn)
    mode_r == ST_S5 ##1 mode_r == ST_S0);
  c_s0_s3_s0: cover property (@(posedge clock) disable iff (!resetn)
    mode_r == ST_S3 ##[1:1000] mode_r == ST_S0);
  c_oc_trip: cover property (@(posedge clock) disable iff (!resetn) ocTrip);
  wire unusedRise = hubRise;
endmodule : acpi_memory_power_sequencer
`default_nettype wire

// ==== hdl/power_seq_consts.svh ====
`ifndef POWER_SEQ_CONSTS_SVH
`define POWER_SEQ_CONSTS_SVH
// Clock rate and derived timing
`define CLK_PERIOD_NS      10
`define PWM_FREQ_KHZ       250
`define PWM_PERIOD_CYC     (1000000 / (`PWM_FREQ_KHZ * `CLK_PERIOD_NS))
`define PWM_CNT_W          9
`define BLANK_TIME_NS      400
`define BLANK_CYC          ((`BLANK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SOFTSTART_STEPS    256
`define OVERTEMP_SET_C     145
`define OVERTEMP_CLR_C     120
`define TEMP_W             8
`define DUTY_W             8
// AXI4-Lite register offsets
`define REG_CONTROL        12'h000
`define REG_STATUS         12'h004
`define REG_MEM_DUTY       12'h008
`define REG_HUB_DUTY       12'h00c
`define REG_TEMP           12'h010
// Control field positions and reset values
`define CTL_SOFTOFF_BIT    0
`define CTL_RESET_VAL      32'h0000_0000
`define DUTY_RESET_VAL     8'h80
`endif

// ==== hdl/power_seq_pkg.sv ====
package power_seq_pkg;
  typedef enum logic [2:0] {
    ST_S5 = 3'b001,
    ST_S0 = 3'b010,
    ST_S3 = 3'b100
  } pmode_t;
  typedef enum logic [3:0] {
    UP_IDLE = 4'b0001,
    UP_STBY = 4'b0010,
    UP_BOOT = 4'b0100,
    UP_RAMP = 4'b1000
  } upseq_t;
endpackage : power_seq_pkg

// ==== hdl/pwm_channel.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "power_seq_consts.svh"
// One buck modulator with soft-start and non-overlapped gates
module pwm_channel (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic                  enable,
  // Control
  input  wire logic                  run,
  input  wire logic                  fastSwitch,
  input  wire logic [`PWM_CNT_W-1:0] phase,
  input  wire logic [`DUTY_W-1:0]    duty,
  input  wire logic [1:0]            ssStep,
  // Gate drive
  output logic                       highGate,
  output logic                       lowGate,
  output logic                       highRise,
  output logic                       ssDone
);
  logic [`PWM_CNT_W-1:0] cnt_r;
  logic [`PWM_CNT_W+1:0] ssAcc_r;
  logic                  ssHeld_r;
  logic                  pwmOn;
  logic                  lowReq;
  logic                  highReq;
  logic                  hgPrev_r;
  wire  [`PWM_CNT_W-1:0] period = `PWM_CNT_W'(`PWM_PERIOD_CYC);
  wire  [`PWM_CNT_W-1:0] half   = `PWM_CNT_W'(`PWM_PERIOD_CYC / 2);
  // Phase added to a count that stops only with enable, so channels stay locked
  wire  [`PWM_CNT_W:0]   shifted = {1'b0, cnt_r} + {1'b0, phase}; // R19
  wire  [`PWM_CNT_W:0]   wrapped = shifted - {1'b0, period};
  wire  [`PWM_CNT_W-1:0] pos    = (shifted >= {1'b0, period}) ? wrapped[`PWM_CNT_W-1:0]
                                                               : shifted[`PWM_CNT_W-1:0];
  // Fast mode folds the count, halving the period without losing lock
  wire  [`PWM_CNT_W-1:0] fold   = (pos >= half) ? pos - half : pos;
  wire  [`PWM_CNT_W:0]   fold2  = {fold, 1'b0};
  wire  [`PWM_CNT_W-1:0] ramp   = fastSwitch ? fold2[`PWM_CNT_W-1:0] : pos; // R10
  wire  [`PWM_CNT_W+7:0] lim    = `PWM_CNT_W'(period) * duty;
  wire  [`DUTY_W-1:0]    ssDuty = ssAcc_r[`DUTY_W+1:2];
  wire  [`DUTY_W-1:0]    effDuty = (ssDone || ssDuty > duty) ? duty : ssDuty;
  wire  [`PWM_CNT_W+7:0] effLim = `PWM_CNT_W'(period) * effDuty;
  // Duty compare against internal ramp
  assign pwmOn    = run && ({ramp, 8'h00} < effLim);
  assign ssDone   = ssHeld_r || (ssAcc_r[`PWM_CNT_W+1:2] >= {1'b0, duty});
  assign highReq  = pwmOn && !lowGate;     // R12
  assign lowReq   = run && !pwmOn && !highGate; // R12
  assign highRise = highGate && !hgPrev_r;
  // Free-running period counter; runs while stopped to keep the phase
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else if (enable) begin
      if (cnt_r >= period - 1'b1) cnt_r <= '0; // R09
      else cnt_r <= cnt_r + 1'b1;
    end
  end
  // Soft-start ramp; done is held so a duty change never restarts it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ssAcc_r  <= '0;
      ssHeld_r <= 1'b0;
    end else if (enable) begin
      if (!run) begin
        ssAcc_r  <= '0;
        ssHeld_r <= 1'b0;
      end else begin
        ssHeld_r <= ssDone;
        if (!ssDone && pos == '0) ssAcc_r <= ssAcc_r + (`PWM_CNT_W+2)'(ssStep); // R17
      end
    end
  end
  // Gates: one cycle dead time through the other gate's state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      highGate <= 1'b0;
      lowGate  <= 1'b0;
      hgPrev_r <= 1'b0;
    end else if (enable) begin
      highGate <= highReq && !lowReq; // R12
      lowGate  <= lowReq;
      hgPrev_r <= highGate;
    end
  end
  a_gate_overlap: assert property (@(posedge clock) disable iff (!resetn)
    !(highGate && lowGate)) else $error("both gates on"); // R12
  a_gate_off: assert property (@(posedge clock) disable iff (!resetn)
    enable && !run |=> !highGate) else $error("gate on while stopped"); // R11
  wire unusedLim = |lim;
endmodule : pwm_channel
`default_nettype wire

// ==== hdl/sync_level.sv ====
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser for a bundle of levels
module sync_level #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         enable,
  input  wire logic [W-1:0] rawIn,
  input  wire logic [W-1:0] initVal,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_r;
  genvar i;
  // Input inversion given per bit so active-low pins idle high from the all-zero reset
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          meta_r[i]  <= 1'b0;
          syncOut[i] <= 1'b0;
        end else if (enable) begin
          meta_r[i]  <= rawIn[i] ^ initVal[i];
          syncOut[i] <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule : sync_level
`default_nettype wire

// ==== sim/power_partner.sv ====
`timescale 1ns/100ps
`default_nettype none
// Supplies, monitors and memory switch node as the sequencer sees them
module power_partner (
  // Clock and stimulus
  input  wire logic clock,
  input  wire logic supplyUp,
  input  wire logic overload,
  // From sequencer
  input  wire logic standbyMonitorEnable,
  input  wire logic bootMonitorEnable,
  input  wire logic memoryHighGate,
  // To sequencer
  output logic      referenceGood,
  output logic      standbySupplyGood,
  output logic      bootSupplyGood,
  output logic      switchNodeBelowThreshold
);
  // Standby and boot good flags only report once their monitor is awake
  always_ff @(posedge clock) begin
    referenceGood     <= supplyUp;
    standbySupplyGood <= supplyUp & standbyMonitorEnable;
    bootSupplyGood    <= supplyUp & bootMonitorEnable;
  end
  // Node is low whenever the high side is off, so only gating and blanking protect
  assign switchNodeBelowThreshold = overload | ~memoryHighGate;
endmodule : power_partner
`default_nettype wire

// ==== sim/tb_acpi_memory_power_sequencer.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "power_seq_consts.svh"
module tb_acpi_memory_power_sequencer;
  localparam int Limit = 60000;
  logic        clock, resetn, sleepToRamN, softOffN, supplyUp, overload;
  logic        referenceGood, standbySupplyGood, bootSupplyGood, switchNodeBelowThreshold;
  logic        memoryHighGate, memoryLowGate, hubHighGate, hubLowGate;
  logic        terminationEnable, terminationOe, memoryRailInRegulation;
  logic        standbyMonitorEnable, bootMonitorEnable;
  logic [7:0]  dieTempC;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [31:0] cyc = '0, memRise = '0, memPeriod = '0, hubOffset = '0;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, clockEnable, termLimit;
  logic        memHiD = 1'b0, hubHiD = 1'b0;
  logic [3:0]  gatesHeld;
  logic [1:0]  bresp, rresp, rr;
  int          mismatches, samplesChecked;

  acpi_memory_power_sequencer i_acpi_memory_power_sequencer (
    .clock, .resetn, .clockEnable, .sleepToRamN, .softOffN, .referenceGood,
    .standbySupplyGood, .bootSupplyGood, .switchNodeBelowThreshold,
    .termCurrentLimit(termLimit), .dieTempC, .memoryHighGate, .memoryLowGate, .hubHighGate,
    .hubLowGate, .terminationEnable, .terminationOe, .standbyMonitorEnable,
    .bootMonitorEnable, .memoryRailInRegulation,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  power_partner i_power_partner (
    .clock, .supplyUp, .overload, .standbyMonitorEnable, .bootMonitorEnable,
    .memoryHighGate, .referenceGood, .standbySupplyGood, .bootSupplyGood,
    .switchNodeBelowThreshold
  );

  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  // Each channel released on its own handshake edge
  task automatic axiWrite(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [11:0] a);
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask : axiRead

  // Mode is polled, since sync and sequencing latency vary
  task automatic waitMode(input logic [2:0] m);
    int n = 0;
    do begin
      axiRead(`REG_STATUS);
      n++;
    end while (rd[2:0] !== m && n < 400);
    check(32'(rd[2:0]), 32'(m));
  endtask : waitMode

  task automatic quiet(input logic [3:0] mask, input int n);
    logic [3:0] seen = 4'h0;
    repeat (n) begin
      @(posedge clock);
      seen |= mask & {memoryHighGate, memoryLowGate, hubHighGate, hubLowGate};
    end
    check(32'(seen), 32'h0);
  endtask : quiet

  // Gate edge timing, overlap watch and hang limit
  always @(posedge clock) begin
    cyc    <= cyc + 1;
    memHiD <= memoryHighGate;
    hubHiD <= hubHighGate;
    if (memoryHighGate && !memHiD) begin
      memPeriod <= cyc - memRise;
      memRise   <= cyc;
    end
    if (hubHighGate && !hubHiD) hubOffset <= cyc - memRise;
    if (resetn) check(32'({memoryHighGate & memoryLowGate, hubHighGate & hubLowGate}), 0);
    if (cyc == Limit) begin
      mismatches++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    {resetn, supplyUp, overload, awvalid, wvalid, bready, arvalid, rready, termLimit} = '0;
    {sleepToRamN, softOffN, clockEnable} = 3'h7;
    {awaddr, araddr, wdata} = '0;
    dieTempC = 8'h19;
    mismatches = 0;
    samplesChecked = 0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    quiet(4'hf, 10);
    check(32'({standbyMonitorEnable, bootMonitorEnable}), 0);
    axiRead(`REG_STATUS);
    check(32'(rd[2:0]), 32'h1);
    axiRead(`REG_MEM_DUTY);
    check(rd, 32'h80);
    axiRead(12'h020);
    check(32'(rr), 32'h2);
    // Small duty keeps the soft-start short
    axiWrite(`REG_MEM_DUTY, 32'h4);
    axiWrite(`REG_HUB_DUTY, 32'h4);
    supplyUp <= 1'b1;
    waitMode(3'b010);
    repeat (20000) if (memoryRailInRegulation !== 1'b1) @(posedge clock);
    check(32'(memoryRailInRegulation), 1);
    // Clock enable low must freeze the gates where they stand
    clockEnable <= 1'b0;
    @(posedge clock);
    gatesHeld = {memoryHighGate, memoryLowGate, hubHighGate, hubLowGate};
    repeat (30) @(posedge clock);
    check(32'({memoryHighGate, memoryLowGate, hubHighGate, hubLowGate}), 32'(gatesHeld));
    clockEnable <= 1'b1;
    repeat (4000) @(posedge clock);
    check(32'(terminationOe), 1);
    check(32'(terminationEnable), 1);
    termLimit <= 1'b1;
    @(posedge clock);
    check(32'(terminationEnable), 0);
    termLimit <= 1'b0;
    check(memPeriod, 400);
    check(hubOffset, 200);
    // On-time below the blanking window must not trip
    overload <= 1'b1;
    repeat (1200) @(posedge clock);
    overload <= 1'b0;
    axiRead(`REG_STATUS);
    check(32'(rd[6]), 0);
    axiWrite(`REG_MEM_DUTY, 32'h40);
    sleepToRamN <= 1'b0;
    waitMode(3'b100);
    overload <= 1'b1;
    quiet(4'h3, 450);
    check(32'(terminationOe), 0);
    repeat (600) @(posedge clock);
    check(memPeriod, 200);
    axiRead(`REG_STATUS);
    check(32'({rd[6], rd[2:0]}), 32'h4);
    overload <= 1'b0;
    sleepToRamN <= 1'b1;
    waitMode(3'b010);
    repeat (800) @(posedge clock);
    overload <= 1'b1;
    waitMode(3'b001);
    check(32'(rd[6]), 1);
    quiet(4'hf, 450);
    overload <= 1'b0;
    axiWrite(`REG_MEM_DUTY, 32'h4);
    softOffN <= 1'b0;
    repeat (10) @(posedge clock);
    softOffN <= 1'b1;
    waitMode(3'b010);
    softOffN <= 1'b0;
    waitMode(3'b001);
    quiet(4'hf, 450);
    check(32'(terminationOe), 0);
    softOffN <= 1'b1;
    waitMode(3'b010);
    axiWrite(`REG_CONTROL, 32'h1);
    waitMode(3'b001);
    axiWrite(`REG_CONTROL, 32'h0);
    waitMode(3'b010);
    // Thermal trip with hysteresis between the two thresholds
    dieTempC <= 8'h91;
    waitMode(3'b001);
    dieTempC <= 8'h82;
    repeat (50) @(posedge clock);
    axiRead(`REG_STATUS);
    check(32'(rd[2:0]), 32'h1);
    dieTempC <= 8'h77;
    waitMode(3'b010);
    test_done();
  end
endmodule : tb_acpi_memory_power_sequencer
`default_nettype wire
